// *** shared/stm_pkg.sv ***
package stm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] STM_OFS_CTRL0     = 3'h0;
    localparam logic [2:0] STM_OFS_CTRL1     = 3'h1;
    localparam logic [2:0] STM_OFS_CNT_LOW   = 3'h2;
    localparam logic [2:0] STM_OFS_CNT_HIGH  = 3'h3;
    localparam logic [2:0] STM_OFS_CMPA_LOW  = 3'h4;
    localparam logic [2:0] STM_OFS_CMPA_HIGH = 3'h5;
    localparam logic [2:0] STM_OFS_CMPP      = 3'h6;
    localparam logic [2:0] STM_OFS_FLAGS     = 3'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STM_C0_PAUSE   = 7;
    localparam int STM_C0_CKS_LSB = 4;
    localparam int STM_C0_ON      = 3;
    localparam int STM_C0_TEN     = 0;
    localparam int STM_FL_A       = 0;
    localparam int STM_FL_P       = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  STM_RST_BYTE  = 8'h00;
    localparam logic [15:0] STM_RST_COUNT = 16'h0000;

    // ------------------------------------------------------------
    // Divider counts and span constants
    // ------------------------------------------------------------
    localparam logic [5:0]  STM_DIV4_MASK  = 6'h03;
    localparam logic [5:0]  STM_DIV16_MASK = 6'h0F;
    localparam logic [5:0]  STM_DIV64_MASK = 6'h3F;
    localparam logic [16:0] STM_SPAN_FULL  = 17'h10000;
    localparam logic [16:0] STM_SPAN_TEN   = 17'h00400;

    // ------------------------------------------------------------
    // Modes, output functions, clock sources
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        STM_MODE_CMP   = 2'h0,
        STM_MODE_CAP   = 2'h1,
        STM_MODE_PWM   = 2'h2,
        STM_MODE_TIMER = 2'h3
    } stm_mode_t;

    typedef enum logic [1:0] {
        STM_IO_NONE = 2'h0,
        STM_IO_LOW  = 2'h1,
        STM_IO_HIGH = 2'h2,
        STM_IO_TOG  = 2'h3
    } stm_io_t;

    typedef enum logic [2:0] {
        STM_CK_DIV4  = 3'h0,
        STM_CK_SYS   = 3'h1,
        STM_CK_DIV16 = 3'h2,
        STM_CK_DIV64 = 3'h3,
        STM_CK_TBC   = 3'h4,
        STM_CK_NONE  = 3'h5,
        STM_CK_RISE  = 3'h6,
        STM_CK_FALL  = 3'h7
    } stm_cks_t;

    typedef struct packed {
        stm_mode_t  mode;
        stm_io_t    out_func;
        logic       output_control;
        logic       output_polarity;
        logic       period_duty_select;
        logic       clear_select;
    } stm_ctrl1_t;

endpackage : stm_pkg

// *** rtl/stm_timer.sv ***
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - Read-only high byte returns counter bits 15..8, zero after reset.
// - Compare-A is 16 bits, written as low and high bytes, zero at reset.
// - Compare-P is 8 bits, matched only against counter upper byte.
// - Clear-select low: compare-P match clears the counter.
// - Mode 00 selects compare-match output operation.
// - Compare mode, clear-select low: clear on P match or overflow; both flags.
// - Clear-select high: clear on A match, only the A flag raised.
// - Compare mode: pin changes only on A match, P match leaves it.
// - A match drives pin high, low or toggles; field zero no change.
// - Timer-on rising sets pin to the output-control initial level.
// - Mode 11 behaves as compare mode, flags included, pin left free.
// - PWM ignores clear-select; period/duty select picks period register.
// - PWM raises a flag on each A match and each P match.
// - PWM: output-control sets active level, function forces level, polarity inverts.
// - Ten-bit variant: period 128 times 3-bit P, zero gives 1024, duty A.
// - Duty at or above period keeps output active all period.
// - Period/duty select set: A sets period, P sets duty.
// - Compare output function: 00 none, 01 low, 10 high, 11 toggle.
// - Timer-on rising clears counter; falling freezes it.
// - Select 0: P period, A duty; select 1 swaps roles.
module stm_timer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic       tbc_tick,
    input  wire logic       ext_clk_in,
    output logic            tm_out,
    output logic            tm_out_en,
    output logic            compare_a_flag,
    output logic            compare_p_flag
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [16:0] p_span(input logic [7:0] p, input logic ten);
        logic [16:0] s;
        s = 17'h00000;
        if (ten)
        begin
            s = (p[2:0] == 3'h0) ? stm_pkg::STM_SPAN_TEN : {7'h00, p[2:0], 7'h00};
        end
        else
        begin
            s = (p == 8'h00) ? stm_pkg::STM_SPAN_FULL : {1'b0, p, 8'h00};
        end
        return s;
    endfunction : p_span

    function automatic logic [16:0] a_span(input logic [15:0] a, input logic ten);
        return ten ? {7'h00, a[9:0]} : {1'b0, a};
    endfunction : a_span

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic                pause_q;
    logic [2:0]          cks_q;
    logic                timer_on_q;
    logic                ten_q;
    stm_pkg::stm_ctrl1_t ctrl1_q;
    logic [15:0]         compare_a_value_q;
    logic [7:0]          compare_p_value_q;
    logic [15:0]         count_q;
    logic                on_prev_q;
    logic                ext_prev_q;
    logic [5:0]          div_q;
    logic                cmp_level_q;

    logic                wr_c0;
    logic                clr_a;
    logic                clr_p;
    logic                tick;
    logic                on_rise;
    logic [16:0]         inc;
    logic [16:0]         span_p;
    logic [16:0]         span_a;
    logic                match_p;
    logic                match_a;
    logic                run;
    logic                is_pwm;
    logic                clear_cnt;
    logic                ev_a;
    logic                ev_p;
    logic                pwm_active;
    logic                out_d;

    assign wr_c0 = reg_write && (reg_addr == stm_pkg::STM_OFS_CTRL0);
    assign clr_a = reg_write && (reg_addr == stm_pkg::STM_OFS_FLAGS)
                   && reg_wdata[stm_pkg::STM_FL_A];
    assign clr_p = reg_write && (reg_addr == stm_pkg::STM_OFS_FLAGS)
                   && reg_wdata[stm_pkg::STM_FL_P];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pause_q    <= 1'b0;
            cks_q      <= 3'h0;
            timer_on_q <= 1'b0;
            ten_q      <= 1'b0;
        end
        else if (wr_c0)
        begin
            pause_q    <= reg_wdata[stm_pkg::STM_C0_PAUSE];
            cks_q      <= reg_wdata[stm_pkg::STM_C0_CKS_LSB +: 3];
            timer_on_q <= reg_wdata[stm_pkg::STM_C0_ON];
            ten_q      <= reg_wdata[stm_pkg::STM_C0_TEN];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl1_q <= stm_pkg::stm_ctrl1_t'(stm_pkg::STM_RST_BYTE);
        end
        else if (reg_write && (reg_addr == stm_pkg::STM_OFS_CTRL1))
        begin
            ctrl1_q <= stm_pkg::stm_ctrl1_t'(reg_wdata);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            compare_a_value_q <= {stm_pkg::STM_RST_BYTE, stm_pkg::STM_RST_BYTE};
            compare_p_value_q <= stm_pkg::STM_RST_BYTE;
        end
        else if (reg_write)
        begin
            if (reg_addr == stm_pkg::STM_OFS_CMPA_LOW)
            begin
                compare_a_value_q[7:0] <= reg_wdata;
            end
            if (reg_addr == stm_pkg::STM_OFS_CMPA_HIGH)
            begin
                compare_a_value_q[15:8] <= reg_wdata;
            end
            if (reg_addr == stm_pkg::STM_OFS_CMPP)
            begin
                compare_p_value_q <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Timer clock selection
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div_q      <= 6'h00;
            ext_prev_q <= 1'b0;
        end
        else
        begin
            div_q      <= div_q + 6'h01;
            ext_prev_q <= ext_clk_in;
        end
    end

    always_comb
    begin
        unique case (stm_pkg::stm_cks_t'(cks_q))
            stm_pkg::STM_CK_DIV4:  tick = (div_q[1:0] == stm_pkg::STM_DIV4_MASK[1:0]);
            stm_pkg::STM_CK_SYS:   tick = 1'b1;
            stm_pkg::STM_CK_DIV16: tick = (div_q[3:0] == stm_pkg::STM_DIV16_MASK[3:0]);
            stm_pkg::STM_CK_DIV64: tick = (div_q == stm_pkg::STM_DIV64_MASK);
            stm_pkg::STM_CK_TBC:   tick = tbc_tick;
            stm_pkg::STM_CK_NONE:  tick = 1'b0;
            stm_pkg::STM_CK_RISE:  tick = ext_clk_in && !ext_prev_q;
            stm_pkg::STM_CK_FALL:  tick = !ext_clk_in && ext_prev_q;
        endcase
    end

    // ------------------------------------------------------------
    // Comparators and counter
    // ------------------------------------------------------------
    assign on_rise = timer_on_q && !on_prev_q;
    assign inc     = {1'b0, count_q} + 17'h00001;
    assign span_p  = p_span(compare_p_value_q, ten_q);
    assign span_a  = a_span(compare_a_value_q, ten_q);
    assign match_p = (inc == span_p);
    assign match_a = (inc == span_a);
    assign is_pwm  = (ctrl1_q.mode == stm_pkg::STM_MODE_PWM);
    assign run     = timer_on_q && !pause_q && tick && !on_rise;

    always_comb
    begin
        clear_cnt = 1'b0;
        ev_a      = 1'b0;
        ev_p      = 1'b0;
        if (run)
        begin
            if (is_pwm)
            begin
                ev_a      = match_a;
                ev_p      = match_p;
                clear_cnt = ctrl1_q.period_duty_select ? match_a : match_p;
            end
            else if (ctrl1_q.clear_select)
            begin
                ev_a      = match_a;
                clear_cnt = match_a;
            end
            else
            begin
                ev_a      = match_a;
                ev_p      = match_p;
                clear_cnt = match_p;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_q   <= stm_pkg::STM_RST_COUNT;
            on_prev_q <= 1'b0;
        end
        else
        begin
            on_prev_q <= timer_on_q;
            if (on_rise)
            begin
                count_q <= stm_pkg::STM_RST_COUNT;
            end
            else if (run)
            begin
                count_q <= clear_cnt ? stm_pkg::STM_RST_COUNT : inc[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt request flags
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            compare_a_flag <= 1'b0;
            compare_p_flag <= 1'b0;
        end
        else
        begin
            compare_a_flag <= ev_a || (compare_a_flag && !clr_a);
            compare_p_flag <= ev_p || (compare_p_flag && !clr_p);
        end
    end

    // ------------------------------------------------------------
    // Output pin
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cmp_level_q <= 1'b0;
        end
        else if (on_rise)
        begin
            cmp_level_q <= ctrl1_q.output_control;
        end
        else if (ev_a && !is_pwm)
        begin
            unique case (ctrl1_q.out_func)
                stm_pkg::STM_IO_NONE: cmp_level_q <= cmp_level_q;
                stm_pkg::STM_IO_LOW:  cmp_level_q <= 1'b0;
                stm_pkg::STM_IO_HIGH: cmp_level_q <= 1'b1;
                stm_pkg::STM_IO_TOG:  cmp_level_q <= !cmp_level_q;
            endcase
        end
    end

    always_comb
    begin
        pwm_active = 1'b0;
        unique case (ctrl1_q.out_func)
            stm_pkg::STM_IO_NONE: pwm_active = 1'b0;
            stm_pkg::STM_IO_LOW:  pwm_active = 1'b1;
            stm_pkg::STM_IO_HIGH: pwm_active = ({1'b0, count_q} <
                                   (ctrl1_q.period_duty_select ? span_p : span_a));
            stm_pkg::STM_IO_TOG:  pwm_active = 1'b0;
        endcase
        if (is_pwm)
        begin
            out_d = (pwm_active ? ctrl1_q.output_control : !ctrl1_q.output_control)
                    ^ ctrl1_q.output_polarity;
        end
        else
        begin
            out_d = cmp_level_q ^ ctrl1_q.output_polarity;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tm_out    <= 1'b0;
            tm_out_en <= 1'b0;
        end
        else
        begin
            tm_out    <= (ctrl1_q.mode == stm_pkg::STM_MODE_TIMER) ? 1'b0 : out_d;
            tm_out_en <= (ctrl1_q.mode == stm_pkg::STM_MODE_CMP) || is_pwm;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata <= stm_pkg::STM_RST_BYTE;
        end
        else if (reg_read)
        begin
            unique case (reg_addr)
                stm_pkg::STM_OFS_CTRL0:     reg_rdata <= {pause_q, cks_q, timer_on_q, 2'h0, ten_q};
                stm_pkg::STM_OFS_CTRL1:     reg_rdata <= ctrl1_q;
                stm_pkg::STM_OFS_CNT_LOW:   reg_rdata <= count_q[7:0];
                stm_pkg::STM_OFS_CNT_HIGH:  reg_rdata <= count_q[15:8];
                stm_pkg::STM_OFS_CMPA_LOW:  reg_rdata <= compare_a_value_q[7:0];
                stm_pkg::STM_OFS_CMPA_HIGH: reg_rdata <= compare_a_value_q[15:8];
                stm_pkg::STM_OFS_CMPP:      reg_rdata <= compare_p_value_q;
                stm_pkg::STM_OFS_FLAGS:     reg_rdata <= {6'h00, compare_p_flag, compare_a_flag};
            endcase
        end
        else
        begin
            reg_rdata <= stm_pkg::STM_RST_BYTE;
        end
    end

endmodule : stm_timer

// *** dv/stm_timer_chk.sv ***
`timescale 1ns/1ps

module stm_timer_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       tbc_tick,
    input wire logic       ext_clk_in,
    input wire logic       tm_out,
    input wire logic       tm_out_en,
    input wire logic       compare_a_flag,
    input wire logic       compare_p_flag
);
    // ----------------
    // Register shadows
    // ----------------
    logic                on_q;
    logic [7:0]          lo_q;
    stm_pkg::stm_ctrl1_t c1_q;
    logic                lvl;
    logic                clr_a;
    logic                clr_p;

    assign lvl   = c1_q.output_control ^ c1_q.output_polarity;
    assign clr_a = reg_write && reg_addr == 3'h7 && reg_wdata[0];
    assign clr_p = reg_write && reg_addr == 3'h7 && reg_wdata[1];

    always_ff @(posedge clk)
        if (rst)
            on_q <= 1'b0;
        else if (reg_write && reg_addr == 3'h0)
            on_q <= reg_wdata[3];

    always_ff @(posedge clk)
        if (rst)
            c1_q <= stm_pkg::stm_ctrl1_t'(8'h00);
        else if (reg_write && reg_addr == 3'h1)
            c1_q <= stm_pkg::stm_ctrl1_t'(reg_wdata);

    always_ff @(posedge clk)
        if (rst)
            lo_q <= 8'h00;
        else if (reg_write && reg_addr == 3'h4)
            lo_q <= reg_wdata;

    // ----------
    // Assertions
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_rdata_cmpa:
        assert property ($past(reg_read) && $past(reg_addr) == 3'h4 |-> reg_rdata == $past(lo_q))
        else $error("compare A low byte read back wrong");
    a_flag_a_sticky:
        assert property (compare_a_flag && !clr_a |=> compare_a_flag)
        else $error("A flag dropped without clear");
    a_flag_p_sticky:
        assert property (compare_p_flag && !clr_p |=> compare_p_flag)
        else $error("P flag dropped without clear");
    a_cmp_pin_enable:
        assert property ((c1_q.mode == stm_pkg::STM_MODE_CMP)[*3] |-> tm_out_en)
        else $error("pin not enabled in compare mode");
    a_timer_no_pin:
        assert property ((c1_q.mode == stm_pkg::STM_MODE_TIMER)[*3] |-> !tm_out_en && !tm_out)
        else $error("pin used in timer mode");
    a_on_init_level:
        assert property ($rose(on_q) && c1_q.mode == stm_pkg::STM_MODE_CMP |-> ##[1:3] tm_out == lvl)
        else $error("pin not set to initial level");
    a_pwm_force_active:
        assert property ((on_q && c1_q.mode == stm_pkg::STM_MODE_PWM
                          && c1_q.out_func == stm_pkg::STM_IO_LOW)[*3] |-> tm_out == lvl)
        else $error("forced active level wrong");
    a_pwm_force_idle:
        assert property ((on_q && c1_q.mode == stm_pkg::STM_MODE_PWM
                          && c1_q.out_func == stm_pkg::STM_IO_NONE)[*3] |-> tm_out == !lvl)
        else $error("forced inactive level wrong");
endmodule : stm_timer_chk

bind stm_timer stm_timer_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tbc_tick(tbc_tick), .ext_clk_in(ext_clk_in), .tm_out(tm_out), .tm_out_en(tm_out_en),
    .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag));

// *** dv/testbench.sv ***
`timescale 1ns/1ps

module testbench;
    logic       clk;
    logic       rst;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_rdata;
    logic       tbc_tick;
    logic       ext_clk_in;
    logic       tm_out;
    logic       tm_out_en;
    logic       compare_a_flag;
    logic       compare_p_flag;
    int         miscompares;
    int         cmp_count;

    stm_timer uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .tbc_tick(tbc_tick), .ext_clk_in(ext_clk_in), .tm_out(tm_out), .tm_out_en(tm_out_en),
        .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // -----
    // Tasks
    // -----
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        check(16'(reg_rdata), 16'(exp));
    endtask : rd

    // Timer off, flags cleared, control written, then on with system clock
    task automatic start(input logic [7:0] c1, input logic ten);
        wr(3'h0, 8'h10);
        wr(3'h7, 8'h03);
        wr(3'h1, c1);
        wr(3'h0, {7'h0C, ten});
    endtask : start

    // Counts high cycles of the pin over one period
    task automatic pwm(input logic ten, input logic [7:0] c1, input logic [15:0] a,
                       input logic [7:0] p, input int per, input int hi);
        int k;
        wr(3'h4, a[7:0]);
        wr(3'h5, a[15:8]);
        wr(3'h6, p);
        start(c1, ten);
        cyc(per + 8);
        k = 0;
        repeat (per)
        begin
            @(posedge clk);
            #1;
            if (tm_out === 1'b1)
                k++;
        end
        check(16'(k), 16'(hi));
    endtask : pwm

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish;
    end

    // ---------
    // Sequences
    // ---------
    initial
    begin
        logic e;
        {rst, reg_write, reg_read, tbc_tick, ext_clk_in} = 5'h10;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        miscompares = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        check(16'({tm_out, compare_a_flag, compare_p_flag}), 16'h0000);
        rd(3'h3, 8'h00);
        rd(3'h4, 8'h00);
        rd(3'h5, 8'h00);
        rd(3'h6, 8'h00);
        wr(3'h4, 8'hA5);
        wr(3'h5, 8'h5A);
        wr(3'h6, 8'hC3);
        wr(3'h3, 8'hFF);
        rd(3'h4, 8'hA5);
        rd(3'h5, 8'h5A);
        rd(3'h6, 8'hC3);
        rd(3'h3, 8'h00);
        wr(3'h4, 8'h10);
        wr(3'h5, 8'h00);
        wr(3'h6, 8'h01);
        for (int i = 0; i < 8; i++)
        begin
            e = (i[1:0] == 2'h0) ? i[2] : (i[1:0] == 2'h3) ? ~i[2] : i[1];
            start({2'h0, i[1:0], i[2], 3'h0}, 1'b0);
            cyc(4);
            check(16'({tm_out_en, tm_out}), 16'({1'b1, i[2]}));
            cyc(30);
            check(16'(tm_out), 16'(e));
            check(16'({compare_a_flag, compare_p_flag}), 16'h0002);
        end
        wr(3'h6, 8'h02);
        start(8'h00, 1'b0);
        cyc(300);
        rd(3'h3, 8'h01);
        cyc(250);
        check(16'({compare_a_flag, compare_p_flag}), 16'h0003);
        rd(3'h3, 8'h00);
        cyc(250);
        wr(3'h0, 8'h10);
        rd(3'h3, 8'h01);
        cyc(300);
        rd(3'h3, 8'h01);
        wr(3'h0, 8'h18);
        rd(3'h3, 8'h00);
        wr(3'h0, 8'h98);
        cyc(300);
        rd(3'h3, 8'h00);
        wr(3'h4, 8'h00);
        wr(3'h5, 8'h02);
        wr(3'h6, 8'h01);
        start(8'h31, 1'b0);
        cyc(300);
        check(16'({compare_a_flag, compare_p_flag, tm_out}), 16'h0000);
        rd(3'h3, 8'h01);
        cyc(250);
        check(16'({compare_a_flag, compare_p_flag, tm_out}), 16'h0005);
        rd(3'h3, 8'h00);
        wr(3'h4, 8'h10);
        wr(3'h5, 8'h00);
        start(8'hC0, 1'b0);
        cyc(300);
        check(16'({compare_a_flag, compare_p_flag, tm_out_en, tm_out}), 16'h000C);
        pwm(1'b0, 8'hA8, 16'h0040, 8'h01, 256, 64);
        check(16'({compare_a_flag, compare_p_flag}), 16'h0003);
        pwm(1'b0, 8'hAC, 16'h0040, 8'h01, 256, 192);
        pwm(1'b0, 8'h98, 16'h0040, 8'h01, 256, 256);
        pwm(1'b0, 8'h88, 16'h0040, 8'h01, 256, 0);
        pwm(1'b0, 8'hAB, 16'h0080, 8'h01, 128, 128);
        pwm(1'b0, 8'hAA, 16'h0200, 8'h01, 512, 256);
        pwm(1'b0, 8'hA8, 16'h0200, 8'h01, 256, 256);
        pwm(1'b1, 8'hA8, 16'h0040, 8'h02, 256, 64);
        pwm(1'b1, 8'hA8, 16'h0100, 8'h00, 1024, 256);
        tally_and_finish;
    end
endmodule : testbench
